// ==== rtl/otfs_top.sv ====
/*
  Output terminal function selector: eight digital output terminals, each
  following the internal status source chosen by its function code.
  Assumes status inputs are on core_clk except the count clock pin.
*/
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - A function code of zero keeps the terminal inactive.
// - Code 17 asserts the terminal from ten seconds before the drive overload trip.
// - Code 18 asserts while running at zero output frequency, never while stopped.
// - Code 22 gives a 500 ms pulse when a sequence program stage ends.
// - Code 23 gives a 500 ms pulse when a full sequence program cycle ends.
// - Code 25 asserts once running time since start exceeds the run-time threshold.
// - Code 26 gives one 1 s pulse when the running time reaches the timing preset.
// - Code 27 pulses one count-clock period when the counter hits its limit, clearing it.
// - Code 28 asserts from the preset count until the counter wraps at its limit.
// - Code 29 asserts while the first analog input is above upper or below lower limit.
// - Code 30 asserts while module temperature is at or above its threshold.
// - Code 31 asserts while the cooling fan runs.
// - Codes 32 to 35 follow bits 12 to 15 of the command word at 0x2000.
// - Codes 36 to 39 give pump one to four start signals when multi-pump is on.
module otfs_top #(
  parameter int unsigned STAGE_PULSE_CYC = otfs_pkg::STAGE_PULSE_CYC,
  parameter int unsigned SEC_CYC         = otfs_pkg::SEC_CYC
) (
  input  wire logic        core_clk,        // Core clock, 10 MHz
  input  wire logic        rst_n,           // Asynchronous reset, active low
  input  wire logic [15:0] addr,            // Register address
  input  wire logic [15:0] wr_data,         // Register write data
  input  wire logic        wr_stb,          // Write strobe
  input  wire logic        rd_stb,          // Read strobe
  output var  logic [15:0] rd_data_q,       // Read data, cycle after rd_stb
  output logic             irq,             // Level interrupt
  input  wire logic        run_active,      // Drive is running
  input  wire logic [15:0] out_freq,        // Output frequency
  input  wire logic        accel_active,    // Frequency rising
  input  wire logic        decel_active,    // Frequency falling
  input  wire logic        dc_brake,        // DC braking applied
  input  wire logic        ovl_active,      // Drive overload integrating
  input  wire logic [15:0] ovl_eta_ms,      // Time left to overload trip, ms
  input  wire logic        sequence_program_step_done,  // Stage end pulse
  input  wire logic        sequence_program_cycle_done, // Cycle end pulse
  input  wire logic        count_clk_pin,   // External count clock pin
  input  wire logic [15:0] first_analog_input, // Analog input value
  input  wire logic [15:0] module_temp,     // Heatsink temperature
  input  wire logic        fan_running,     // Cooling fan on
  input  wire logic [3:0]  pump_start,      // Pump staging requests
  output var  logic [7:0]  term_out_q       // Output terminals, high active
);
  // ==========================================================================
  // Registers
  logic [5:0]  func_q [8];
  logic [5:0]  func_d [8];
  logic [15:0] run_time_threshold_q, run_time_threshold_d;
  logic [15:0] timing_preset_value_q, timing_preset_value_d;
  logic [15:0] counter_limit_setting_q, counter_limit_setting_d;
  logic [15:0] count_preset_q, count_preset_d;
  logic [15:0] analog_window_upper_q, analog_window_upper_d;
  logic [15:0] analog_window_lower_q, analog_window_lower_d;
  logic [15:0] module_temp_threshold_q, module_temp_threshold_d;
  logic        pump_en_q, pump_en_d;
  logic [15:0] comm_q, comm_d;
  logic [5:0]  irq_en_q, irq_en_d;
  logic [5:0]  irq_stat_q, irq_stat_d;
  logic [5:0]  events;
  logic [15:0] rd_data_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] secs_q, secs_d;
  logic [31:0] presc_q, presc_d;

  function automatic logic is_func_addr(input logic [15:0] a);
    return a[15:3] == otfs_pkg::FUNC_SEL_BASE[15:3];
  endfunction

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      func_d[i] = func_q[i];
    run_time_threshold_d    = run_time_threshold_q;
    timing_preset_value_d   = timing_preset_value_q;
    counter_limit_setting_d = counter_limit_setting_q;
    count_preset_d          = count_preset_q;
    analog_window_upper_d   = analog_window_upper_q;
    analog_window_lower_d   = analog_window_lower_q;
    module_temp_threshold_d = module_temp_threshold_q;
    pump_en_d               = pump_en_q;
    comm_d                  = comm_q;
    irq_en_d                = irq_en_q;
    irq_stat_d              = irq_stat_q;
    if (wr_stb)
    begin
      if (is_func_addr(addr))
        func_d[addr[2:0]] = wr_data[5:0];
      unique case (addr)
        otfs_pkg::RUN_TIME_THR:  run_time_threshold_d    = wr_data;
        otfs_pkg::TIMING_PRESET: timing_preset_value_d   = wr_data;
        otfs_pkg::COUNT_LIMIT:   counter_limit_setting_d = wr_data;
        otfs_pkg::COUNT_PRESET:  count_preset_d          = wr_data;
        otfs_pkg::AI_WIN_UPPER:  analog_window_upper_d   = wr_data;
        otfs_pkg::AI_WIN_LOWER:  analog_window_lower_d   = wr_data;
        otfs_pkg::TEMP_THR:      module_temp_threshold_d = wr_data;
        otfs_pkg::CTRL:          pump_en_d = wr_data[otfs_pkg::CTRL_PUMP_EN_BIT];
        otfs_pkg::IRQ_CLEAR:     irq_stat_d = irq_stat_q & ~wr_data[5:0];
        otfs_pkg::IRQ_ENABLE:    irq_en_d = wr_data[5:0];
        otfs_pkg::COMM_CMD:      comm_d = wr_data;
        default:                 ;
      endcase
    end
    // Hardware set wins over a simultaneous clear
    irq_stat_d = irq_stat_d | events;
    rd_data_d  = 16'h0000;
    if (rd_stb)
    begin
      if (is_func_addr(addr))
        rd_data_d = {10'h000, func_q[addr[2:0]]};
      unique case (addr)
        otfs_pkg::RUN_TIME_THR:  rd_data_d = run_time_threshold_q;
        otfs_pkg::TIMING_PRESET: rd_data_d = timing_preset_value_q;
        otfs_pkg::COUNT_LIMIT:   rd_data_d = counter_limit_setting_q;
        otfs_pkg::COUNT_PRESET:  rd_data_d = count_preset_q;
        otfs_pkg::AI_WIN_UPPER:  rd_data_d = analog_window_upper_q;
        otfs_pkg::AI_WIN_LOWER:  rd_data_d = analog_window_lower_q;
        otfs_pkg::TEMP_THR:      rd_data_d = module_temp_threshold_q;
        otfs_pkg::CTRL:          rd_data_d = {15'h0000, pump_en_q};
        otfs_pkg::IRQ_STATUS:    rd_data_d = {10'h000, irq_stat_q};
        otfs_pkg::IRQ_ENABLE:    rd_data_d = {10'h000, irq_en_q};
        otfs_pkg::TERM_STATE:    rd_data_d = {8'h00, term_out_q};
        otfs_pkg::COUNT_VALUE:   rd_data_d = cnt_q;
        otfs_pkg::RUN_SECONDS:   rd_data_d = secs_q;
        otfs_pkg::COMM_CMD:      rd_data_d = comm_q;
        default:                 ;
      endcase
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 8; i++)
        func_q[i] <= otfs_pkg::F_NONE;
      run_time_threshold_q    <= otfs_pkg::REG_RST;
      timing_preset_value_q   <= otfs_pkg::REG_RST;
      counter_limit_setting_q <= otfs_pkg::LIMIT_RST;
      count_preset_q          <= otfs_pkg::LIMIT_RST;
      analog_window_upper_q   <= otfs_pkg::LIMIT_RST;
      analog_window_lower_q   <= otfs_pkg::REG_RST;
      module_temp_threshold_q <= otfs_pkg::LIMIT_RST;
      pump_en_q               <= 1'b0;
      comm_q                  <= otfs_pkg::REG_RST;
      irq_en_q                <= 6'h00;
      irq_stat_q              <= 6'h00;
      rd_data_q               <= 16'h0000;
    end
    else
    begin
      func_q                  <= func_d;
      run_time_threshold_q    <= run_time_threshold_d;
      timing_preset_value_q   <= timing_preset_value_d;
      counter_limit_setting_q <= counter_limit_setting_d;
      count_preset_q          <= count_preset_d;
      analog_window_upper_q   <= analog_window_upper_d;
      analog_window_lower_q   <= analog_window_lower_d;
      module_temp_threshold_q <= module_temp_threshold_d;
      pump_en_q               <= pump_en_d;
      comm_q                  <= comm_d;
      irq_en_q                <= irq_en_d;
      irq_stat_q              <= irq_stat_d;
      rd_data_q               <= rd_data_d;
    end
  end

  // ==========================================================================
  // External counter
  logic cclk_s1_q, cclk_s2_q, cclk_s3_q;
  logic cnt_max_q, cnt_max_d;
  logic cnt_set_q, cnt_set_d;
  logic cclk_rise;
  logic [15:0] cnt_inc;

  always_comb
  begin
    cclk_rise = cclk_s2_q & ~cclk_s3_q;
    cnt_inc   = cnt_q + 16'h0001;
    cnt_d     = cnt_q;
    cnt_max_d = cnt_max_q;
    cnt_set_d = cnt_set_q;
    if (cclk_rise)
    begin
      cnt_max_d = 1'b0;
      if (cnt_inc >= counter_limit_setting_q)
      begin
        cnt_d     = 16'h0000;
        cnt_max_d = 1'b1;
        cnt_set_d = 1'b0;
      end
      else
      begin
        cnt_d = cnt_inc;
        if (cnt_inc == count_preset_q)
          cnt_set_d = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Running time
  logic        run_q;
  logic        sec_tick;
  logic        run_reached_q, run_reached_d;

  always_comb
  begin
    sec_tick      = run_active && (presc_q == SEC_CYC - 1);
    presc_d       = presc_q;
    secs_d        = secs_q;
    run_reached_d = (secs_q > run_time_threshold_q);
    if (run_active && !run_q)
    begin
      presc_d = 32'h0;
      secs_d  = 16'h0000;
    end
    else if (sec_tick)
    begin
      presc_d = 32'h0;
      if (secs_q != 16'hFFFF)
        secs_d = secs_q + 16'h0001;
    end
    else if (run_active)
      presc_d = presc_q + 32'h1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cclk_s1_q     <= 1'b0;
      cclk_s2_q     <= 1'b0;
      cclk_s3_q     <= 1'b0;
      cnt_q         <= 16'h0000;
      cnt_max_q     <= 1'b0;
      cnt_set_q     <= 1'b0;
      run_q         <= 1'b0;
      presc_q       <= 32'h0;
      secs_q        <= 16'h0000;
      run_reached_q <= 1'b0;
    end
    else
    begin
      cclk_s1_q     <= count_clk_pin;
      cclk_s2_q     <= cclk_s1_q;
      cclk_s3_q     <= cclk_s2_q;
      cnt_q         <= cnt_d;
      cnt_max_q     <= cnt_max_d;
      cnt_set_q     <= cnt_set_d;
      run_q         <= run_active;
      presc_q       <= presc_d;
      secs_q        <= secs_d;
      run_reached_q <= run_reached_d;
    end
  end

  // ==========================================================================
  // Pulse sources
  logic [2:0] str_trig;
  logic [2:0] str_out;
  logic       timing_hit;

  assign timing_hit = sec_tick && (secs_q + 16'h0001 == timing_preset_value_q);
  assign str_trig   = {timing_hit, sequence_program_cycle_done, sequence_program_step_done};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_str
      otfs_stretch #(
        .LEN (g == 2 ? SEC_CYC : STAGE_PULSE_CYC)
      ) u_str (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .trig     (str_trig[g]),
        .pulse_q  (str_out[g])
      );
    end
  endgenerate

  assign events = {run_reached_d & ~run_reached_q, cnt_set_d & ~cnt_set_q,
                   cnt_max_d & ~cnt_max_q, str_trig};

  // ==========================================================================
  // Source selection
  logic [63:0] src;
  logic [7:0]  term_out_d;

  function automatic logic pick(input logic [5:0] code, input logic [63:0] s);
    return s[code];
  endfunction

  always_comb
  begin
    src = 64'h0;
    src[otfs_pkg::F_PREWARN]  = ovl_active && (ovl_eta_ms <= otfs_pkg::PREWARN_MS);
    src[otfs_pkg::F_ZERO_SPD] = run_active && (out_freq == 16'h0000);
    src[otfs_pkg::F_ACCEL]    = accel_active;
    src[otfs_pkg::F_DECEL]    = decel_active;
    src[otfs_pkg::F_DC_BRAKE] = dc_brake;
    src[otfs_pkg::F_STEP]     = str_out[0];
    src[otfs_pkg::F_CYCLE]    = str_out[1];
    src[otfs_pkg::F_RUN_TIME] = run_reached_q;
    src[otfs_pkg::F_TIMING]   = str_out[2];
    src[otfs_pkg::F_CNT_MAX]  = cnt_max_q;
    src[otfs_pkg::F_CNT_SET]  = cnt_set_q;
    src[otfs_pkg::F_AI_WIN]   = (first_analog_input > analog_window_upper_q) ||
                                (first_analog_input < analog_window_lower_q);
    src[otfs_pkg::F_TEMP]     = module_temp >= module_temp_threshold_q;
    src[otfs_pkg::F_FAN]      = fan_running;
    for (int b = 0; b < 4; b++)
    begin
      src[otfs_pkg::F_COMM0 + b] = comm_q[otfs_pkg::COMM_FIRST_BIT + b];
      src[otfs_pkg::F_PUMP0 + b] = pump_en_q && pump_start[b];
    end
    for (int i = 0; i < 8; i++)
      term_out_d[i] = pick(func_q[i], src);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      term_out_q <= 8'h00;
    else
      term_out_q <= term_out_d;
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  zero_code_a: assert property (func_q[0] == otfs_pkg::F_NONE |=> !term_out_q[0])
    else $error("Code zero terminal active");
  prewarn_a: assert property (func_q[0] == otfs_pkg::F_PREWARN && ovl_active &&
    ovl_eta_ms <= 16'h2710 |=> term_out_q[0]) else $error("Overload prewarning missed");
  zero_speed_a: assert property (func_q[0] == otfs_pkg::F_ZERO_SPD && !run_active
    |=> !term_out_q[0]) else $error("Zero speed active while stopped");
  decel_a: assert property (func_q[0] == otfs_pkg::F_DECEL && decel_active
    |=> term_out_q[0]) else $error("Deceleration not shown");
  reserved_a: assert property (func_q[0] == otfs_pkg::F_RESERVED |=> !term_out_q[0])
    else $error("Reserved code active");
  cnt_max_a: assert property (cclk_rise && cnt_inc >= counter_limit_setting_q
    |=> cnt_max_q && cnt_q == 16'h0000 && !cnt_set_q) else $error("Counter limit wrap wrong");
  cnt_max_width_a: assert property (cnt_max_q && !cclk_rise |=> cnt_max_q)
    else $error("Count limit pulse ended early");
  window_a: assert property (func_q[0] == otfs_pkg::F_AI_WIN &&
    first_analog_input > analog_window_upper_q |=> term_out_q[0]) else $error("Window high missed");
  comm_a: assert property (func_q[0] == otfs_pkg::F_COMM0 |=>
    term_out_q[0] == $past(comm_q[12])) else $error("Command bit not followed");
  pump_a: assert property (func_q[0] == otfs_pkg::F_PUMP0 && !pump_en_q |=>
    !term_out_q[0]) else $error("Pump start without multi-pump");
  irq_set_a: assert property (sequence_program_step_done |=> irq_stat_q[0])
    else $error("Step event lost");

  step_c: cover property (func_q[0] == otfs_pkg::F_STEP && $rose(term_out_q[0]));
  cnt_wrap_c: cover property ($rose(cnt_max_q) ##[1:100] $rose(cnt_set_q));
  irq_c: cover property ($rose(irq));
endmodule // otfs_top

`default_nettype wire

// ==== inc/otfs_pkg.sv ====
/*
  Constants for the output terminal function selector: register offsets,
  field positions, reset values, function codes and timing counts.
  Assumes a 10 MHz core clock and a 16-bit register port.
*/
`default_nettype none

package otfs_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_KHZ       = CLK_HZ / 1000;
  localparam int unsigned PREWARN_S     = 10;
  localparam int unsigned PREWARN_MS    = PREWARN_S * 1000;
  localparam int unsigned STAGE_PULSE_MS = 500;
  localparam int unsigned STAGE_PULSE_CYC = CLK_KHZ * STAGE_PULSE_MS;
  localparam int unsigned TIMING_PULSE_S = 1;
  localparam int unsigned SEC_CYC       = CLK_HZ * TIMING_PULSE_S;

  // ==========================================================================
  // Geometry
  localparam int unsigned N_TERM  = 8;
  localparam int unsigned CODE_W  = 6;
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned DATA_W  = 16;

  // ==========================================================================
  // Register offsets
  localparam logic [15:0] FUNC_SEL_BASE  = 16'h0000; // Eight words, one per terminal
  localparam logic [15:0] RUN_TIME_THR   = 16'h0010;
  localparam logic [15:0] TIMING_PRESET  = 16'h0011;
  localparam logic [15:0] COUNT_LIMIT    = 16'h0012;
  localparam logic [15:0] COUNT_PRESET   = 16'h0013;
  localparam logic [15:0] AI_WIN_UPPER   = 16'h0014;
  localparam logic [15:0] AI_WIN_LOWER   = 16'h0015;
  localparam logic [15:0] TEMP_THR       = 16'h0016;
  localparam logic [15:0] CTRL           = 16'h0017;
  localparam logic [15:0] IRQ_STATUS     = 16'h0018;
  localparam logic [15:0] IRQ_CLEAR      = 16'h0019;
  localparam logic [15:0] IRQ_ENABLE     = 16'h001A;
  localparam logic [15:0] TERM_STATE     = 16'h001B;
  localparam logic [15:0] COUNT_VALUE    = 16'h001C;
  localparam logic [15:0] RUN_SECONDS    = 16'h001D;
  localparam logic [15:0] COMM_CMD       = 16'h2000;

  // ==========================================================================
  // Fields and reset values
  localparam int unsigned CTRL_PUMP_EN_BIT = 0;
  localparam int unsigned COMM_FIRST_BIT   = 12;
  localparam int unsigned IRQ_W            = 6;
  localparam int unsigned EV_STEP          = 0;
  localparam int unsigned EV_CYCLE         = 1;
  localparam int unsigned EV_TIMING        = 2;
  localparam int unsigned EV_CNT_MAX       = 3;
  localparam int unsigned EV_CNT_PRESET    = 4;
  localparam int unsigned EV_RUN_TIME      = 5;
  localparam logic [15:0] REG_RST          = 16'h0000;
  localparam logic [15:0] LIMIT_RST        = 16'hFFFF;

  // ==========================================================================
  // Function codes
  localparam logic [5:0] F_NONE     = 6'h00;
  localparam logic [5:0] F_PREWARN  = 6'h11;
  localparam logic [5:0] F_ZERO_SPD = 6'h12;
  localparam logic [5:0] F_ACCEL    = 6'h13;
  localparam logic [5:0] F_DECEL    = 6'h14;
  localparam logic [5:0] F_DC_BRAKE = 6'h15;
  localparam logic [5:0] F_STEP     = 6'h16;
  localparam logic [5:0] F_CYCLE    = 6'h17;
  localparam logic [5:0] F_RESERVED = 6'h18;
  localparam logic [5:0] F_RUN_TIME = 6'h19;
  localparam logic [5:0] F_TIMING   = 6'h1A;
  localparam logic [5:0] F_CNT_MAX  = 6'h1B;
  localparam logic [5:0] F_CNT_SET  = 6'h1C;
  localparam logic [5:0] F_AI_WIN   = 6'h1D;
  localparam logic [5:0] F_TEMP     = 6'h1E;
  localparam logic [5:0] F_FAN      = 6'h1F;
  localparam logic [5:0] F_COMM0    = 6'h20;
  localparam logic [5:0] F_PUMP0    = 6'h24;
endpackage

`default_nettype wire

// ==== rtl/otfs_stretch.sv ====
/*
  Pulse stretcher: a one-cycle trigger gives an output held high for LEN
  clock cycles; a new trigger restarts the count.
  Assumes the trigger is on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module otfs_stretch #(
  parameter int unsigned LEN = 16
) (
  input  wire logic core_clk,  // Core clock
  input  wire logic rst_n,     // Asynchronous reset, active low
  input  wire logic trig,      // One-cycle trigger
  output var  logic pulse_q    // Stretched pulse
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        pulse_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (trig)
      cnt_d = LEN;
    else if (cnt_q != 32'h0)
      cnt_d = cnt_q - 32'h1;
    pulse_d = (cnt_d != 32'h0);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q   <= 32'h0;
      pulse_q <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      pulse_q <= pulse_d;
    end
  end

  stretch_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(pulse_q) |-> pulse_q[*8]) else $error("Stretched pulse too short");
endmodule // otfs_stretch

`default_nettype wire

// ==== test/otfs_relay_model.sv ====
/*
  Relay bank model: senses the eight terminals and keeps the width in
  core_clk cycles of the last completed high pulse of each.
  Assumes terminals are high active and sampled on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module otfs_relay_model (
  input  wire logic        core_clk,    // Core clock
  input  wire logic        rst_n,       // Asynchronous reset, active low
  input  wire logic [7:0]  term,        // Terminal levels
  output var  logic [15:0] last_w [8]   // Last pulse width per terminal
);
  logic [15:0] run_q [8];
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!rst_n)
      begin
        run_q[i]  <= '0;
        last_w[i] <= '0;
      end
      else if (term[i]) run_q[i] <= run_q[i] + 16'h0001;
      else
      begin
        if (run_q[i] != 16'h0000) last_w[i] <= run_q[i];
        run_q[i] <= '0;
      end
    end
  end
endmodule // otfs_relay_model

`default_nettype wire

// ==== test/otfs_top_tb_top.sv ====
/*
  Testbench for the terminal function selector: register tasks, level codes,
  timed pulses and the interrupt. Assumes pulse lengths shortened to 20.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch t=%0t value differs", $time); end end

module otfs_top_tb_top;
  logic core_clk = 0, rst_n = 0, wr_stb = 0, rd_stb = 0, run_active = 0, accel_active = 0;
  logic decel_active = 0, dc_brake = 0, ovl_active = 0, step_done = 0, cycle_done = 0;
  logic fan_running = 0, irq, cnt_pin = 0;
  logic [15:0] addr = '0, wr_data = '0, rd_data_q, out_freq = '0, ovl_eta_ms = '0;
  logic [15:0] ai = '0, temp = '0, last_w [8];
  logic [3:0] pump_start = '0;
  logic [7:0] term_out_q;
  int bad_count = 0, comparisons = 0;
  always #50 core_clk = ~core_clk;

  otfs_top #(.STAGE_PULSE_CYC(20), .SEC_CYC(20)) otfs_top_inst (
    .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data_q(rd_data_q), .irq(irq), .run_active(run_active),
    .out_freq(out_freq), .accel_active(accel_active), .decel_active(decel_active),
    .dc_brake(dc_brake), .ovl_active(ovl_active), .ovl_eta_ms(ovl_eta_ms),
    .sequence_program_step_done(step_done), .sequence_program_cycle_done(cycle_done),
    .count_clk_pin(cnt_pin), .first_analog_input(ai), .module_temp(temp),
    .fan_running(fan_running), .pump_start(pump_start), .term_out_q(term_out_q));
  otfs_relay_model otfs_relay_model_inst (.core_clk(core_clk), .rst_n(rst_n),
    .term(term_out_q), .last_w(last_w));

  task cyc(input int n); repeat (n) @(posedge core_clk); endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a; wr_data <= d; wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge core_clk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 `CHK(rd_data_q, e)
  endtask
  // One count pin period of 8 core cycles, 4 high and 4 low
  task cnt_edge;
    @(posedge core_clk);
    cnt_pin <= 1'b1;
    cyc(4);
    cnt_pin <= 1'b0;
    cyc(3);
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Sources all true when on, each just past its boundary when off
  task set_src(input logic on);
    @(posedge core_clk);
    ovl_active <= 1'b1; ovl_eta_ms <= on ? 16'h2710 : 16'h2711; run_active <= on;
    accel_active <= on; decel_active <= on; dc_brake <= on; fan_running <= on;
    ai <= on ? 16'h0200 : 16'h0100; temp <= on ? 16'h0050 : 16'h004F; pump_start <= 4'hF;
    wr(otfs_pkg::COMM_CMD, on ? 16'hF000 : 16'h0000);
    wr(otfs_pkg::CTRL, {15'h0000, on});
  endtask
  task wait_w(input int i);
    for (int k = 0; k < 200 && last_w[i] == 16'h0000; k++) @(posedge core_clk);
    if (last_w[i] == 16'h0000)
    begin
      bad_count++;
      $display("mismatch t=%0t pulse never ended", $time);
      end_of_test();
    end
  endtask

  initial
  begin
    cyc(3);
    rst_n <= 1'b1;
    `CHK(term_out_q, 8'h00)
    rd(otfs_pkg::COUNT_LIMIT, 16'hFFFF);
    rd(16'h0100, 16'h0000);
    wr(otfs_pkg::AI_WIN_UPPER, 16'h0100);
    wr(otfs_pkg::AI_WIN_LOWER, 16'h0010);
    wr(otfs_pkg::TEMP_THR, 16'h0050);
    for (int on = 1; on >= 0; on--)
    begin
      set_src(on[0]);
      for (int c = 0; c < 40; c++)
      begin
        if (c > 0 && c < 17 || c > 21 && c < 29 && c != 24) continue;
        wr(otfs_pkg::FUNC_SEL_BASE, 16'(c));
        cyc(3);
        `CHK(term_out_q[0], on[0] && c != 0 && c != 24)
      end
      $display("level codes done, sources on=%0d", on);
    end
    wr(otfs_pkg::FUNC_SEL_BASE + 16'h0001, {10'h000, otfs_pkg::F_STEP});
    wr(otfs_pkg::FUNC_SEL_BASE + 16'h0002, {10'h000, otfs_pkg::F_CYCLE});
    wr(otfs_pkg::FUNC_SEL_BASE + 16'h0003, {10'h000, otfs_pkg::F_RUN_TIME});
    wr(otfs_pkg::FUNC_SEL_BASE + 16'h0004, {10'h000, otfs_pkg::F_TIMING});
    wr(otfs_pkg::TIMING_PRESET, 16'h0001);
    wr(otfs_pkg::RUN_TIME_THR, 16'h0001);
    wr(otfs_pkg::IRQ_ENABLE, 16'h003F);
    @(posedge core_clk);
    step_done <= 1'b1; cycle_done <= 1'b1; run_active <= 1'b1;
    @(posedge core_clk);
    step_done <= 1'b0; cycle_done <= 1'b0;
    cyc(10);
    `CHK(term_out_q[3], 1'b0)
    wait_w(1);
    `CHK(last_w[1], 16'h0014)
    `CHK(last_w[2], 16'h0014)
    wait_w(4);
    `CHK(last_w[4], 16'h0014)
    cyc(30);
    `CHK(term_out_q[3], 1'b1)
    run_active <= 1'b0;
    $display("pulse codes done");
    rd(otfs_pkg::IRQ_STATUS, 16'h0027);
    `CHK(irq, 1'b1)
    wr(otfs_pkg::IRQ_ENABLE, 16'h0000);
    #1 `CHK(irq, 1'b0)
    wr(otfs_pkg::IRQ_ENABLE, 16'h003F);
    wr(otfs_pkg::IRQ_CLEAR, 16'h003F);
    rd(otfs_pkg::IRQ_STATUS, 16'h0000);
    `CHK(irq, 1'b0)
    $display("interrupt test done");
    wr(otfs_pkg::COUNT_LIMIT, 16'h0004);
    wr(otfs_pkg::COUNT_PRESET, 16'h0002);
    wr(otfs_pkg::FUNC_SEL_BASE + 16'h0005, {10'h000, otfs_pkg::F_CNT_MAX});
    wr(otfs_pkg::FUNC_SEL_BASE + 16'h0006, {10'h000, otfs_pkg::F_CNT_SET});
    cnt_edge();
    cnt_edge();
    `CHK(term_out_q[6:5], 2'b10)
    rd(otfs_pkg::COUNT_VALUE, 16'h0002);
    cnt_edge();
    cnt_edge();
    `CHK(term_out_q[6:5], 2'b01)
    cnt_edge();
    `CHK(last_w[5], 16'h0008)
    rd(otfs_pkg::COUNT_VALUE, 16'h0001);
    $display("counter test done");
    end_of_test();
  end
endmodule // otfs_top_tb_top

`default_nettype wire
